// File: rtl/mvd_pkg.sv
// package for the move and option instruction decode slice
// assumes a 12-bit instruction word and an 8-bit data path
package mvd_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int INSTR_W = 12;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;

    // ****************************************
    // encodings and field positions
    // ****************************************
    localparam logic [5:0] COPY_REG_OPC = 6'h08;    // 0010 00
    localparam logic [3:0] LOAD_LIT_OPC = 4'hC;     // 1100
    localparam logic [6:0] STORE_ACC_OPC = 7'h01;   // 0000 001
    localparam logic [11:0] IDLE_WORD = 12'h000;
    localparam logic [11:0] OPTION_WORD = 12'h002;
    localparam int DEST_BIT = 5;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] OPTION_RST = 8'hFF;
    localparam logic ZERO_RST = 1'b0;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_COPY,
        OP_LOAD,
        OP_STORE,
        OP_IDLE,
        OP_OPTION
    } mvd_op_t;

    // one instruction offered by fetch
    typedef struct packed {
        logic valid;
        logic [11:0] word;
    } mvd_instr_t;

    // write request toward the register file
    typedef struct packed {
        logic en;
        logic [4:0] addr;
        logic [7:0] data;
    } mvd_wr_t;

endpackage

// File: rtl/mvd_decode.sv
// decode and execute for the move, literal load, store, idle and option
// instructions; fetch and the register file sit outside on sys_clk
// the register file read port answers in the cycle that shows the address
// and takes the registered write request one cycle after the instruction
//
// Contract
// - copy, destination bit clear: addressed register into accumulator
// - copy with destination bit set writes value back to same register
// - copy sets zero flag from moved value; one word, one cycle
// - literal load puts low eight bits into accumulator, flags untouched
`timescale 1ns/100ps
module mvd_decode
    import mvd_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // instruction from fetch
    input wire mvd_instr_t instr,
    // register file read port, combinational on the address
    output logic [4:0] rd_addr,
    input wire logic [7:0] rd_data,
    // register file write request
    output mvd_wr_t wr_req,
    // architectural state
    output logic [7:0] acc,
    output logic zero_flag,
    output logic [7:0] option_cfg,
    // status toward the rest of the core
    output logic handled,
    output logic unknown_instr
);

    // ****************************************
    // decode
    // ****************************************
    function automatic mvd_op_t decode(input logic [11:0] w);
        mvd_op_t op;
        op = OP_NONE;
        if (w[11:6] == COPY_REG_OPC) begin
            op = OP_COPY;
        end else if (w[11:8] == LOAD_LIT_OPC) begin
            op = OP_LOAD;
        end else if (w[11:5] == STORE_ACC_OPC) begin
            op = OP_STORE;
        end else if (w == IDLE_WORD) begin
            op = OP_IDLE;
        end else if (w == OPTION_WORD) begin
            op = OP_OPTION;
        end
        return op;
    endfunction

    // ****************************************
    // instruction fields
    // ****************************************
    // the register field feeds both the read port and the write request
    function automatic logic [4:0] reg_field(input logic [11:0] w);
        return w[4:0];
    endfunction

    function automatic logic [7:0] lit_field(input logic [11:0] w);
        return w[7:0];
    endfunction

    function automatic logic dest_field(input logic [11:0] w);
        return w[DEST_BIT];
    endfunction

    // ****************************************
    // decoded instruction
    // ****************************************
    mvd_op_t op;
    logic dest_reg;

    always_comb begin
        op = instr.valid ? decode(instr.word) : OP_NONE;
        dest_reg = dest_field(instr.word);
    end

    // ****************************************
    // accumulator
    // ****************************************
    logic [7:0] acc_r;
    logic [7:0] acc_nxt;

    always_comb begin
        acc_nxt = acc_r;
        unique case (op)
            OP_COPY: begin
                // a write-back copy leaves the accumulator alone
                if (!dest_reg) begin
                    acc_nxt = rd_data;
                end
            end
            OP_LOAD: begin
                acc_nxt = lit_field(instr.word);
            end
            OP_STORE: begin
            end
            OP_IDLE: begin
            end
            OP_OPTION: begin
            end
            OP_NONE: begin
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            acc_r <= ACC_RST;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // ****************************************
    // zero flag
    // ****************************************
    logic zero_r;
    logic zero_nxt;

    always_comb begin
        zero_nxt = zero_r;
        unique case (op)
            OP_COPY: begin
                // either destination updates it, so a copy doubles as a test
                zero_nxt = (rd_data == 8'h00);
            end
            OP_LOAD: begin
            end
            OP_STORE: begin
            end
            OP_IDLE: begin
            end
            OP_OPTION: begin
            end
            OP_NONE: begin
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            zero_r <= ZERO_RST;
        end else begin
            zero_r <= zero_nxt;
        end
    end

    // ****************************************
    // timer and prescaler configuration
    // ****************************************
    logic [7:0] option_r;
    logic [7:0] option_nxt;

    always_comb begin
        option_nxt = option_r;
        if (op == OP_OPTION) begin
            option_nxt = acc_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            option_r <= OPTION_RST;
        end else begin
            option_r <= option_nxt;
        end
    end

    // ****************************************
    // register file write request
    // ****************************************
    mvd_wr_t wr_r;
    mvd_wr_t wr_nxt;

    // registered, so the file sees a clean one-cycle pulse with zeroed fields
    always_comb begin
        wr_nxt = '0;
        unique case (op)
            OP_COPY: begin
                if (dest_reg) begin
                    wr_nxt.en = 1'h1;
                    wr_nxt.addr = reg_field(instr.word);
                    wr_nxt.data = rd_data;
                end
            end
            OP_STORE: begin
                wr_nxt.en = 1'h1;
                wr_nxt.addr = reg_field(instr.word);
                wr_nxt.data = acc_r;
            end
            OP_LOAD: begin
            end
            OP_IDLE: begin
            end
            OP_OPTION: begin
            end
            OP_NONE: begin
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_r <= '0;
        end else begin
            wr_r <= wr_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // read address is combinational so copy completes in one cycle
    assign rd_addr = reg_field(instr.word);
    assign wr_req = wr_r;
    assign acc = acc_r;
    assign zero_flag = zero_r;
    assign option_cfg = option_r;

    // ****************************************
    // status
    // ****************************************
    // refused words move no state; the flag lets the core route them on
    assign handled = (op != OP_NONE);
    assign unknown_instr = instr.valid && (op == OP_NONE);

endmodule // mvd_decode

// File: test/mvd_props.sv
// assertions on the move, load, store and option results of mvd_decode
// assumes one clock domain with srst synchronous active high
`timescale 1ns/100ps
module mvd_props import mvd_pkg::*; (
    // watched ports
    input wire logic sys_clk,
    input wire logic srst,
    input wire mvd_instr_t instr,
    input wire logic [7:0] rd_data,
    input wire mvd_wr_t wr_req,
    input wire logic [7:0] acc,
    input wire logic zero_flag,
    input wire logic [7:0] option_cfg
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire logic v = instr.valid;
    wire logic [11:0] w = instr.word;
    wire logic [4:0] rd_addr_w = w[4:0];
    wire logic is_copy = v && w[11:6] == COPY_REG_OPC;
    wire logic is_load = v && w[11:8] == LOAD_LIT_OPC;
    wire logic is_store = v && w[11:5] == STORE_ACC_OPC;
    wire logic is_idle = v && w == IDLE_WORD;
    wire logic is_option = v && w == OPTION_WORD;
    // no write request may follow anything but a write-back copy or a store
    wire logic no_write = !(is_copy && w[5]) && !is_store;

    // ****************************************
    // properties
    // ****************************************
    property p_copy_acc;
        is_copy && !w[5] |=> acc == $past(rd_data)
            && zero_flag == ($past(rd_data) == 8'h00);
    endproperty
    a_copy_acc: assert property (p_copy_acc)
        else $error("copy into accumulator wrong");
    property p_copy_reg;
        is_copy && w[5] |=> $stable(acc)
            && wr_req == {1'h1, $past(rd_addr_w), $past(rd_data)}
            && zero_flag == ($past(rd_data) == 8'h00);
    endproperty
    a_copy_reg: assert property (p_copy_reg)
        else $error("copy back to register wrong");
    property p_load;
        is_load |=> acc == $past(w[7:0]) && $stable(zero_flag);
    endproperty
    a_load: assert property (p_load)
        else $error("literal load wrong");
    property p_store;
        is_store |=> wr_req == {1'h1, $past(rd_addr_w), $past(acc)}
            && $stable(zero_flag);
    endproperty
    a_store: assert property (p_store)
        else $error("store wrong");
    property p_option;
        is_option |=> option_cfg == $past(acc) && $stable(acc)
            && $stable(zero_flag);
    endproperty
    a_option: assert property (p_option)
        else $error("option load wrong");
    property p_idle;
        is_idle |=> $stable(acc) && $stable(zero_flag)
            && $stable(option_cfg) && !wr_req.en;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle word changed state");
    property p_no_write;
        no_write |=> wr_req == '0;
    endproperty
    a_no_write: assert property (p_no_write)
        else $error("write request without cause");
    property p_reset;
        disable iff (1'h0) srst |=> acc == ACC_RST && zero_flag == ZERO_RST
            && option_cfg == OPTION_RST && wr_req == '0;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset values wrong");
endmodule // mvd_props
bind mvd_decode mvd_props u_props (.sys_clk(sys_clk), .srst(srst),
    .instr(instr), .rd_data(rd_data), .wr_req(wr_req), .acc(acc),
    .zero_flag(zero_flag), .option_cfg(option_cfg));

// File: test/move_and_option_instr_decode_tb_top.sv
// random instruction stream into mvd_decode checked against a model
// the bench plays fetch and the register file itself
`timescale 1ns/100ps
module move_and_option_instr_decode_tb_top import mvd_pkg::*; ;
    logic sys_clk = 0, srst = 1, zero_flag, handled, unknown_instr;
    logic [4:0] rd_addr;
    logic [7:0] acc, option_cfg, rf [32];
    logic [31:0] seed = 64190;
    mvd_instr_t instr = '0;
    mvd_wr_t wr_req;
    int error_cnt = 0, samples_checked = 0;
    int m_acc = ACC_RST, m_opt = OPTION_RST, m_z = ZERO_RST;
    always #12.5 sys_clk = ~sys_clk;
    mvd_decode dut (.sys_clk(sys_clk), .srst(srst), .instr(instr),
        .rd_addr(rd_addr), .rd_data(rf[rd_addr]), .wr_req(wr_req),
        .acc(acc), .zero_flag(zero_flag), .option_cfg(option_cfg),
        .handled(handled), .unknown_instr(unknown_instr));
    task automatic chk(input logic [13:0] g, input logic [13:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: %h not %h", $time, g, e);
        end
    endtask
    task automatic step;
        logic [11:0] w;
        logic [7:0] d;
        logic [2:0] k;
        mvd_wr_t ew;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        k = seed[2:0];
        // load literal: every low bit is literal, none left to fill
        w = k == 0 ? {COPY_REG_OPC, seed[13:8]} : k == 1 ? {LOAD_LIT_OPC,
            seed[15:8]} : k == 2 ? {STORE_ACC_OPC, seed[12:8]} : k == 3 ?
            OPTION_WORD : k == 4 ? IDLE_WORD : k == 5 ? {4'hD, seed[15:8]} :
            {7'h00, seed[12:8] | 5'h03};
        instr = '{k != 7, w};
        d = rf[w[4:0]];
        ew = '0;
        #1;
        chk(14'(rd_addr), 14'(w[4:0]));
        chk({handled, unknown_instr}, 14'(k < 5 ? 2 : k < 7));
        if (k == 0) begin
            m_z = d == 0;
            if (w[5]) ew = '{1'b1, w[4:0], d};
            else m_acc = d;
        end
        if (k == 1) m_acc = w[7:0];
        if (k == 2) ew = '{1'b1, w[4:0], 8'(m_acc)};
        if (k == 3) m_opt = m_acc;
        @(negedge sys_clk);
        chk(14'(acc), 14'(m_acc));
        chk(14'(zero_flag), 14'(m_z));
        chk(14'(option_cfg), 14'(m_opt));
        chk(wr_req, ew);
        if (ew.en) rf[ew.addr] = ew.data;
    endtask
    task automatic apply_reset;
        srst = 1;
        instr = '0;
        repeat (2) @(negedge sys_clk);
        srst = 0;
        m_acc = ACC_RST;
        m_opt = OPTION_RST;
        m_z = ZERO_RST;
        chk(14'(acc), 14'(m_acc));
        chk(14'(zero_flag), 14'(m_z));
        chk(14'(option_cfg), 14'(m_opt));
        chk(wr_req, 14'h0000);
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        // register 0 holds zero so copies also hit the zero flag
        for (int n = 0; n < 32; n++) rf[n] = 8'(n * 37);
        apply_reset();
        repeat (200) step();
        // a second reset mid-stream must drop the state back again
        apply_reset();
        repeat (200) step();
        wrap_up();
    end
    // 400 steps need about 10 us
    initial begin
        #50000;
        error_cnt++;
        wrap_up();
    end
endmodule // move_and_option_instr_decode_tb_top
